/* File: include/dfc_pkg.sv */
// Constants, field layout and carrier types of the drive frequency command select block.
// Assumes one 125 MHz control clock; frequencies are signed counts of 0.01 Hz.
package dfc_pkg;

	// ****************************************
	// Widths and scaling
	// ****************************************
	localparam int FREQ_W = 18;
	localparam int GAIN_SHIFT = 12;
	localparam logic signed [33:0] LINK_FULL = 34'sh0000_4e20;
	localparam logic signed [26:0] PCT_FULL = 27'sh000_0064;
	localparam int CLK_PERIOD_NS = 8;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] A_PRI_SRC = 8'h00;
	localparam logic [7:0] A_SEC_SRC = 8'h04;
	localparam logic [7:0] A_AUX_CFG = 8'h08;
	localparam logic [7:0] A_GAIN_PRI = 8'h0c;
	localparam logic [7:0] A_BIAS_PRI = 8'h10;
	localparam logic [7:0] A_GAIN_SEC = 8'h14;
	localparam logic [7:0] A_GAIN_AUX = 8'h18;
	localparam logic [7:0] A_CTRL = 8'h1c;
	localparam logic [7:0] A_HIGH = 8'h20;
	localparam logic [7:0] A_LOW = 8'h24;
	localparam logic [7:0] A_MAX = 8'h28;
	localparam logic [7:0] A_LINK_S = 8'h2c;
	localparam logic [7:0] A_LINK_H = 8'h30;
	localparam logic [7:0] A_KEYPAD = 8'h34;
	localparam logic [7:0] A_LOSS = 8'h38;
	localparam logic [7:0] A_STATUS = 8'h3c;

	// ****************************************
	// Field positions of the control word
	// ****************************************
	localparam int CTRL_POL_BIT = 0;
	localparam int CTRL_INV_BIT = 1;
	localparam int CTRL_LOWACT_BIT = 2;
	localparam int CTRL_SEC_BIT = 3;
	localparam int CTRL_LINKDEF_BIT = 4;
	localparam int CTRL_THERM_BIT = 5;
	localparam int CTRL_AMODE_BIT = 6;
	localparam int CTRL_LE_LSB = 8;
	localparam int CTRL_PLM_LSB = 12;

	// ****************************************
	// Codes
	// ****************************************
	localparam logic [2:0] SRC_KEYPAD = 3'h0;
	localparam logic [2:0] SRC_TERM_V = 3'h1;
	localparam logic [2:0] SRC_TERM_C = 3'h2;
	localparam logic [2:0] SRC_TERM_ALT = 3'h3;
	localparam logic [1:0] AUX_ONE = 2'h1;
	localparam logic [1:0] AUX_TWO = 2'h2;
	localparam logic [7:0] LOSS_STOP = 8'h00;
	localparam logic [7:0] LOSS_OFF = 8'hff;
	localparam logic [7:0] PCT_MAX = 8'h64;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RST_GAIN = 16'h1000;
	localparam logic [15:0] RST_MAX = 16'h1770;
	localparam logic [15:0] RST_HIGH = 16'h1770;
	localparam logic [15:0] RST_LOW = 16'h0000;
	localparam logic [15:0] RST_CTRL = 16'h0010;
	localparam logic [7:0] RST_LOSS = 8'hff;

	typedef logic signed [FREQ_W-1:0] dfc_freq_type;

	typedef struct packed {
		logic signed [FREQ_W-1:0] term_v;
		logic signed [FREQ_W-1:0] term_c;
		logic c_present;
		logic loss_v;
		logic loss_c;
		logic loss_alt;
	} dfc_analog_type;

	typedef struct packed {
		logic [2:0] pri_src;
		logic [2:0] sec_src;
		logic [1:0] aux_a;
		logic [1:0] aux_b;
		logic [1:0] aux_c;
		logic [15:0] gain_pri;
		logic signed [15:0] bias_pri;
		logic [15:0] gain_sec;
		logic [15:0] gain_aux;
		logic [15:0] ctrl;
		logic [15:0] high;
		logic [15:0] low;
		logic [15:0] fmax;
		logic signed [15:0] link_s;
		logic [15:0] link_h;
		logic [15:0] keypad;
		logic [7:0] loss;
	} dfc_cfg_type;

	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		dfc_cfg_type cfg;
		logic signed [FREQ_W-1:0] freq_ref;
		logic signed [FREQ_W-1:0] hold;
		logic stop_req;
		logic loss_active;
		logic [31:0] rdata;
	} dfc_state_type;

endpackage : dfc_pkg

/* File: rtl/dfc_core.sv */
// Drive frequency command select: source choice, conditioning and limiting of the frequency reference.
// Assumes a register master on clk, analog values already in 0.01 Hz units on clk, asynchronous digital inputs.
// Summary of operation
// R1: High limiter clamps to upper bound
// R2: Low limiter clamps to lower bound
// R3: Zero limiter replaces negatives with zero
// R4: Gain multiplies analog reference by factor
// R5: Adder outputs signed sum of inputs
// R6: OR asserts when any input asserted
// R7: Negated OR asserts when any input deasserted
// R8: AND asserts only when both asserted
// R9: Inverter gives the opposite level
// R10: Mapped link enable input steers link path
// R11: Setting value selects matching numbered input
// R12: Process loop mode one to three overrides
// R13: Unipolar voltage input is zero limited on the main path only
// R14: Analog terminal mode; absent input reads zero
// R15: Analog loss switches to continue frequency
// R16: Bias only on primary; others gain only
// R17: Inverse action only for analog sources
// R18: Signed link word, 20000 is maximum
// R19: Unsigned link word in 0.01 Hz
// R20: Signed word wins unless it is zero
// R21: Below low limit hold or stop
// R22: Reference registered once per clock
`timescale 1ns/100ps
module dfc_core
(
	clk,
	rst_b,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	general_input,
	analog_in,
	pid_freq,
	freq_ref,
	stop_req,
	loss_active
);
	input wire logic clk;
	input wire logic rst_b;
	input wire logic [7:0] reg_addr;
	input wire logic [31:0] reg_wdata;
	input wire logic reg_wr;
	input wire logic reg_rd;
	output logic [31:0] reg_rdata;
	input wire logic [4:0] general_input;
	input wire dfc_pkg::dfc_analog_type analog_in;
	input wire dfc_pkg::dfc_freq_type pid_freq;
	output dfc_pkg::dfc_freq_type freq_ref;
	output logic stop_req;
	output logic loss_active;

	// ****************************************
	// Logic elements
	// ****************************************
	function automatic logic lg_or(input logic [4:0] a);
		lg_or = |a; // R6
	endfunction : lg_or

	function automatic logic lg_nor(input logic [4:0] a);
		lg_nor = ~&a; // R7
	endfunction : lg_nor

	function automatic logic lg_and(input logic a, input logic b);
		lg_and = a & b; // R8
	endfunction : lg_and

	function automatic logic lg_not(input logic a);
		lg_not = ~a; // R9
	endfunction : lg_not

	function automatic dfc_pkg::dfc_freq_type clamp_hi(input dfc_pkg::dfc_freq_type a,
		input dfc_pkg::dfc_freq_type hi);
		clamp_hi = (a > hi) ? hi : a; // R1
	endfunction : clamp_hi

	function automatic dfc_pkg::dfc_freq_type clamp_lo(input dfc_pkg::dfc_freq_type a,
		input dfc_pkg::dfc_freq_type lo);
		clamp_lo = (a < lo) ? lo : a; // R2
	endfunction : clamp_lo

	function automatic dfc_pkg::dfc_freq_type zero_lim(input dfc_pkg::dfc_freq_type a);
		zero_lim = clamp_lo(a, '0); // R3
	endfunction : zero_lim

	function automatic dfc_pkg::dfc_freq_type gain_mul(input dfc_pkg::dfc_freq_type a, input logic [15:0] g);
		logic signed [34:0] p;
		p = a * $signed({1'b0, g}); // R4
		gain_mul = dfc_pkg::dfc_freq_type'(p >>> dfc_pkg::GAIN_SHIFT);
	endfunction : gain_mul

	// Saturates instead of wrapping so a large aux sum cannot flip the direction
	function automatic dfc_pkg::dfc_freq_type add_sat(input dfc_pkg::dfc_freq_type a,
		input dfc_pkg::dfc_freq_type b);
		logic signed [18:0] s;
		s = 19'(a) + 19'(b); // R5
		if (s > 19'sh1ffff)
		begin
			add_sat = 18'sh1ffff;
		end
		else if (s < -19'sh20000)
		begin
			add_sat = -18'sh20000;
		end
		else
		begin
			add_sat = s[17:0];
		end
	endfunction : add_sat

	function automatic dfc_pkg::dfc_freq_type widen(input logic [15:0] v);
		widen = {2'b00, v};
	endfunction : widen

	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync;
	logic rst_n_int;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_sync <= 2'h0;
		end
		else
		begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	assign rst_n_int = rst_sync[1];

	// ****************************************
	// Datapath
	// ****************************************
	dfc_pkg::dfc_state_type st;
	dfc_pkg::dfc_state_type next_st;
	dfc_pkg::dfc_cfg_type c;
	dfc_pkg::dfc_freq_type v_in;
	dfc_pkg::dfc_freq_type cur_in;
	dfc_pkg::dfc_freq_type alt_in;
	dfc_pkg::dfc_freq_type fmax;
	logic [2:0] le_idx;
	logic [4:0] le_mask;
	logic link_sel;
	logic c_ok;
	logic [2:0] src;
	logic use_pri;
	dfc_pkg::dfc_freq_type raw;
	dfc_pkg::dfc_freq_type main_ref;
	dfc_pkg::dfc_freq_type aux1;
	dfc_pkg::dfc_freq_type aux2;
	dfc_pkg::dfc_freq_type local_ref;
	dfc_pkg::dfc_freq_type link_ref;
	logic signed [33:0] link_p;
	logic lost;
	logic loss_now;
	logic signed [26:0] hold_p;
	dfc_pkg::dfc_freq_type sel_ref;
	dfc_pkg::dfc_freq_type mag;
	logic neg;
	logic below;

	assign c = st.cfg;
	assign fmax = widen(c.fmax);

	// Terminal 12 is voltage; the multi-purpose terminal is current or voltage by its mode
	always_comb
	begin
		v_in = analog_in.term_v;
		c_ok = lg_and(analog_in.c_present, lg_not(c.ctrl[dfc_pkg::CTRL_THERM_BIT])); // R14
		cur_in = (c_ok && !c.ctrl[dfc_pkg::CTRL_AMODE_BIT]) ? analog_in.term_c : '0; // R14
		alt_in = (c_ok && c.ctrl[dfc_pkg::CTRL_AMODE_BIT]) ? analog_in.term_c : '0; // R14
	end

	// Link enable may sit on any one of the five general inputs
	always_comb
	begin
		le_idx = c.ctrl[dfc_pkg::CTRL_LE_LSB +: 3];
		le_mask = '0;
		for (int i = 0; i < 5; i++)
		begin
			le_mask[i] = (le_idx == 3'(i + 1));
		end
		if (lg_or(le_mask))
		begin
			link_sel = lg_or(st.sync2 & le_mask); // R10
		end
		else
		begin
			link_sel = c.ctrl[dfc_pkg::CTRL_LINKDEF_BIT];
		end
	end

	// Main source: primary or secondary
	always_comb
	begin
		use_pri = !c.ctrl[dfc_pkg::CTRL_SEC_BIT];
		src = use_pri ? c.pri_src : c.sec_src;
		case (src) // R11
			dfc_pkg::SRC_KEYPAD: raw = widen(c.keypad);
			dfc_pkg::SRC_TERM_V: raw = v_in;
			dfc_pkg::SRC_TERM_C: raw = cur_in;
			dfc_pkg::SRC_TERM_ALT: raw = alt_in;
			default: raw = '0;
		endcase
		main_ref = raw;
		if (src != dfc_pkg::SRC_KEYPAD)
		begin
			if (use_pri)
			begin
				main_ref = add_sat(gain_mul(raw, c.gain_pri), 18'(c.bias_pri)); // R16
			end
			else
			begin
				main_ref = gain_mul(raw, c.gain_sec); // R16
			end
			if (src == dfc_pkg::SRC_TERM_V && c.ctrl[dfc_pkg::CTRL_POL_BIT])
			begin
				main_ref = zero_lim(main_ref); // R13
			end
			if (c.ctrl[dfc_pkg::CTRL_INV_BIT])
			begin
				main_ref = add_sat(fmax, -main_ref); // R17
			end
		end
	end

	// Auxiliary sources, gain only; terminal 12 ahead of current ahead of alternate voltage
	always_comb
	begin
		if (c.aux_a == dfc_pkg::AUX_ONE)
		begin
			aux1 = v_in;
		end
		else if (c.aux_b == dfc_pkg::AUX_ONE)
		begin
			aux1 = cur_in;
		end
		else if (c.aux_c == dfc_pkg::AUX_ONE)
		begin
			aux1 = alt_in;
		end
		else
		begin
			aux1 = '0;
		end
		if (c.aux_a == dfc_pkg::AUX_TWO)
		begin
			aux2 = v_in;
		end
		else if (c.aux_b == dfc_pkg::AUX_TWO)
		begin
			aux2 = cur_in;
		end
		else if (c.aux_c == dfc_pkg::AUX_TWO)
		begin
			aux2 = alt_in;
		end
		else
		begin
			aux2 = '0;
		end
		local_ref = add_sat(main_ref, add_sat(gain_mul(aux1, c.gain_aux), gain_mul(aux2, c.gain_aux))); // R16
	end

	// Link words
	always_comb
	begin
		link_p = (34'(c.link_s) * $signed({18'h0, c.fmax})) / dfc_pkg::LINK_FULL; // R18
		if (c.link_s != 16'sh0000)
		begin
			link_ref = link_p[17:0]; // R20
		end
		else
		begin
			link_ref = widen(c.link_h); // R19
		end
	end

	// Loss is watched only while an analog input feeds the main path
	always_comb
	begin
		case (src)
			dfc_pkg::SRC_TERM_V: lost = analog_in.loss_v;
			dfc_pkg::SRC_TERM_C: lost = analog_in.loss_c;
			dfc_pkg::SRC_TERM_ALT: lost = analog_in.loss_alt;
			default: lost = 1'b0;
		endcase
		loss_now = lost && !link_sel && c.loss != dfc_pkg::LOSS_OFF; // R15
		hold_p = (27'(st.freq_ref) * $signed({19'h0, c.loss})) / dfc_pkg::PCT_FULL;
	end

	// ****************************************
	// State update
	// ****************************************
	always_comb
	begin
		next_st = st;
		next_st.sync1 = general_input;
		next_st.sync2 = st.sync1;
		next_st.rdata = '0;
		next_st.loss_active = loss_now;
		if (loss_now && !st.loss_active)
		begin
			if (c.loss == dfc_pkg::LOSS_STOP || c.loss > dfc_pkg::PCT_MAX)
			begin
				next_st.hold = '0; // R15
			end
			else
			begin
				next_st.hold = hold_p[17:0]; // R15
			end
		end
		if (c.ctrl[dfc_pkg::CTRL_PLM_LSB +: 2] != 2'h0)
		begin
			sel_ref = pid_freq; // R12
		end
		else if (link_sel)
		begin
			sel_ref = link_ref;
		end
		else if (loss_now)
		begin
			sel_ref = st.loss_active ? st.hold : next_st.hold; // R15
		end
		else
		begin
			sel_ref = local_ref;
		end
		neg = sel_ref < 0;
		mag = neg ? add_sat('0, -sel_ref) : sel_ref;
		mag = clamp_hi(mag, widen(c.high)); // R1
		below = mag < widen(c.low);
		next_st.stop_req = 1'b0;
		if (below && c.ctrl[dfc_pkg::CTRL_LOWACT_BIT])
		begin
			mag = '0; // R21
			next_st.stop_req = 1'b1; // R21
		end
		else
		begin
			mag = clamp_lo(mag, widen(c.low)); // R2
		end
		next_st.freq_ref = neg ? -mag : mag; // R22
		if (reg_wr)
		begin
			case (reg_addr)
				dfc_pkg::A_PRI_SRC: next_st.cfg.pri_src = reg_wdata[2:0];
				dfc_pkg::A_SEC_SRC: next_st.cfg.sec_src = reg_wdata[2:0];
				dfc_pkg::A_AUX_CFG: {next_st.cfg.aux_c, next_st.cfg.aux_b, next_st.cfg.aux_a} = reg_wdata[5:0];
				dfc_pkg::A_GAIN_PRI: next_st.cfg.gain_pri = reg_wdata[15:0];
				dfc_pkg::A_BIAS_PRI: next_st.cfg.bias_pri = reg_wdata[15:0];
				dfc_pkg::A_GAIN_SEC: next_st.cfg.gain_sec = reg_wdata[15:0];
				dfc_pkg::A_GAIN_AUX: next_st.cfg.gain_aux = reg_wdata[15:0];
				dfc_pkg::A_CTRL: next_st.cfg.ctrl = reg_wdata[15:0];
				dfc_pkg::A_HIGH: next_st.cfg.high = reg_wdata[15:0];
				dfc_pkg::A_LOW: next_st.cfg.low = reg_wdata[15:0];
				dfc_pkg::A_MAX: next_st.cfg.fmax = reg_wdata[15:0];
				dfc_pkg::A_LINK_S: next_st.cfg.link_s = reg_wdata[15:0];
				dfc_pkg::A_LINK_H: next_st.cfg.link_h = reg_wdata[15:0];
				dfc_pkg::A_KEYPAD: next_st.cfg.keypad = reg_wdata[15:0];
				dfc_pkg::A_LOSS: next_st.cfg.loss = reg_wdata[7:0];
				default: next_st.cfg = st.cfg;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				dfc_pkg::A_PRI_SRC: next_st.rdata = {29'h0, c.pri_src};
				dfc_pkg::A_SEC_SRC: next_st.rdata = {29'h0, c.sec_src};
				dfc_pkg::A_AUX_CFG: next_st.rdata = {26'h0, c.aux_c, c.aux_b, c.aux_a};
				dfc_pkg::A_GAIN_PRI: next_st.rdata = {16'h0, c.gain_pri};
				dfc_pkg::A_BIAS_PRI: next_st.rdata = {16'h0, c.bias_pri};
				dfc_pkg::A_GAIN_SEC: next_st.rdata = {16'h0, c.gain_sec};
				dfc_pkg::A_GAIN_AUX: next_st.rdata = {16'h0, c.gain_aux};
				dfc_pkg::A_CTRL: next_st.rdata = {16'h0, c.ctrl};
				dfc_pkg::A_HIGH: next_st.rdata = {16'h0, c.high};
				dfc_pkg::A_LOW: next_st.rdata = {16'h0, c.low};
				dfc_pkg::A_MAX: next_st.rdata = {16'h0, c.fmax};
				dfc_pkg::A_LINK_S: next_st.rdata = {16'h0, c.link_s};
				dfc_pkg::A_LINK_H: next_st.rdata = {16'h0, c.link_h};
				dfc_pkg::A_KEYPAD: next_st.rdata = {16'h0, c.keypad};
				dfc_pkg::A_LOSS: next_st.rdata = {24'h0, c.loss};
				// Status: link path, inputs all high flag, loss, stop, reference
				dfc_pkg::A_STATUS: next_st.rdata = {5'h00, link_sel, lg_not(lg_nor(st.sync2)), st.loss_active,
					st.stop_req, st.sync2, st.freq_ref};
				default: next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_int)
	begin
		if (!rst_n_int)
		begin
			st <= '{sync1: 5'h00, sync2: 5'h00, freq_ref: '0, hold: '0, stop_req: 1'b0, loss_active: 1'b0,
				rdata: 32'h0000_0000,
				cfg: '{pri_src: dfc_pkg::SRC_KEYPAD, sec_src: dfc_pkg::SRC_KEYPAD, aux_a: 2'h0, aux_b: 2'h0,
				aux_c: 2'h0, gain_pri: dfc_pkg::RST_GAIN, bias_pri: 16'sh0000, gain_sec: dfc_pkg::RST_GAIN,
				gain_aux: dfc_pkg::RST_GAIN, ctrl: dfc_pkg::RST_CTRL, high: dfc_pkg::RST_HIGH,
				low: dfc_pkg::RST_LOW, fmax: dfc_pkg::RST_MAX, link_s: 16'sh0000, link_h: 16'h0000,
				keypad: 16'h0000, loss: dfc_pkg::RST_LOSS}};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign freq_ref = st.freq_ref;
	assign stop_req = st.stop_req;
	assign loss_active = st.loss_active;

endmodule : dfc_core

/* File: tb/dfc_cmd_model.sv */
// Source model for the frequency command select block: analog terminals, process loop and digital inputs.
// Assumes the bench calls its tasks from one process; each value changes just after a rising edge.
`timescale 1ns/100ps
module dfc_cmd_model
(
	input wire logic clk,
	output dfc_pkg::dfc_analog_type analog_in,
	output dfc_pkg::dfc_freq_type pid_freq,
	output logic [4:0] general_input
);
	logic signed [17:0] c_val;
	logic c_on;

	initial
	begin
		analog_in = '0;
		pid_freq = '0;
		general_input = 5'h00;
		c_val = '0;
		c_on = 1'b0;
	end

	// ****************************************
	// Terminal with nothing applied toggles so a stale value never passes
	// ****************************************
	always @(posedge clk)
	begin
		analog_in.term_c <= c_on ? c_val : ~analog_in.term_c;
		analog_in.c_present <= c_on;
	end

	task set_term(input dfc_pkg::dfc_freq_type v);
		@(posedge clk);
		analog_in.term_v <= v;
	endtask : set_term

	task set_cur(input logic on, input dfc_pkg::dfc_freq_type v);
		@(posedge clk);
		c_on <= on;
		c_val <= v;
	endtask : set_cur

	// Loss flags in order alternate voltage, current, terminal 12
	task set_loss(input logic [2:0] l);
		@(posedge clk);
		{analog_in.loss_alt, analog_in.loss_c, analog_in.loss_v} <= l;
	endtask : set_loss

	task set_pid(input dfc_pkg::dfc_freq_type p);
		@(posedge clk);
		pid_freq <= p;
	endtask : set_pid

	task set_inputs(input logic [4:0] g);
		@(posedge clk);
		general_input <= g;
	endtask : set_inputs
endmodule : dfc_cmd_model

/* File: tb/dfc_core_asserts.sv */
// Concurrent checks on the ports of the frequency command select block.
// Assumes register bus and reference outputs share clk and rst_b; limits are shadowed from bus writes.
`timescale 1ns/100ps
module dfc_core_asserts
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire dfc_pkg::dfc_freq_type pid_freq,
	input wire dfc_pkg::dfc_freq_type freq_ref,
	input wire logic stop_req,
	input wire logic loss_active
);
	logic [15:0] high_sh;
	logic [15:0] low_sh;
	logic [1:0] plm_sh;
	logic [7:0] loss_sh;
	logic [17:0] mag;

	// ****************************************
	// Shadows of the settings the checks depend on
	// ****************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			high_sh <= dfc_pkg::RST_HIGH;
			low_sh <= dfc_pkg::RST_LOW;
			plm_sh <= 2'h0;
			loss_sh <= dfc_pkg::RST_LOSS;
		end
		else if (reg_wr)
		begin
			if (reg_addr == dfc_pkg::A_HIGH) high_sh <= reg_wdata[15:0];
			if (reg_addr == dfc_pkg::A_LOW) low_sh <= reg_wdata[15:0];
			if (reg_addr == dfc_pkg::A_CTRL) plm_sh <= reg_wdata[13:12];
			if (reg_addr == dfc_pkg::A_LOSS) loss_sh <= reg_wdata[7:0];
		end
	end

	assign mag = freq_ref[17] ? 18'(-freq_ref) : 18'(freq_ref);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// ****************************************
	// Properties
	// ****************************************
	sequence s_stat_rd;
		reg_rd && reg_addr == dfc_pkg::A_STATUS;
	endsequence

	property p_rd_idle;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	property p_unmapped;
		reg_rd && reg_addr > 8'h3c |=> reg_rdata == 32'h0;
	endproperty
	property p_high;
		mag <= {2'h0, $past(high_sh)};
	endproperty
	property p_low;
		freq_ref != 18'sh0 |-> mag >= {2'h0, $past(low_sh)};
	endproperty
	property p_stop;
		stop_req |-> freq_ref == 18'sh0;
	endproperty
	property p_pid;
		$past(plm_sh) != 2'h0 && !$past(pid_freq[17]) && $past(pid_freq) <= {2'h0, $past(high_sh)}
			&& $past(pid_freq) >= {2'h0, $past(low_sh)} |-> freq_ref == $past(pid_freq);
	endproperty
	property p_loss_off;
		$past(loss_sh) == dfc_pkg::LOSS_OFF |-> !loss_active;
	endproperty
	property p_status_ref;
		s_stat_rd |=> reg_rdata[17:0] == $past(freq_ref);
	endproperty
	property p_status_flags;
		s_stat_rd |=> reg_rdata[23] == $past(stop_req) && reg_rdata[24] == $past(loss_active);
	endproperty
	property p_status_and;
		s_stat_rd |=> reg_rdata[25] == (&reg_rdata[22:18]);
	endproperty

	a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read answer");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_high: assert property (p_high) else $error("reference above high limit");
	a_low: assert property (p_low) else $error("reference below low limit");
	a_stop: assert property (p_stop) else $error("stop request with nonzero reference");
	a_pid: assert property (p_pid) else $error("process loop reference not passed");
	a_loss_off: assert property (p_loss_off) else $error("loss reported while disabled");
	a_status_ref: assert property (p_status_ref) else $error("status reference mismatch");
	a_status_flags: assert property (p_status_flags) else $error("status flags mismatch");
	a_status_and: assert property (p_status_and) else $error("status all-high bit mismatch");
endmodule : dfc_core_asserts

bind dfc_core dfc_core_asserts i_dfc_core_asserts
(
	.clk(clk),
	.rst_b(rst_b),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.pid_freq(pid_freq),
	.freq_ref(freq_ref),
	.stop_req(stop_req),
	.loss_active(loss_active)
);

/* File: tb/dfc_core_tb.sv */
// Self-checking bench of the frequency command select block.
// Assumes the source model drives the analog, process loop and digital inputs; bench owns the register bus.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) \
	begin err_total++; $display("FAIL %s expected %0h seen %0h", nm, e, g); end end
module dfc_core_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] d;
	logic [4:0] general_input;
	dfc_pkg::dfc_analog_type analog_in;
	dfc_pkg::dfc_freq_type pid_freq;
	dfc_pkg::dfc_freq_type freq_ref;
	logic stop_req;
	logic loss_active;
	int err_total = 0;
	int n_compared = 0;
	logic [7:0] ra [16] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c,
		8'h30, 8'h34, 8'h38, 8'h40};
	logic [31:0] rv [16] = '{32'h0, 32'h0, 32'h0, 32'h1000, 32'h0, 32'h1000, 32'h1000, 32'h0010, 32'h1770, 32'h0,
		32'h1770, 32'h0, 32'h0, 32'h0, 32'hff, 32'h0};

	always #(dfc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

	dfc_core i_dfc_core
	(
		.clk(clk),
		.rst_b(rst_b),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.general_input(general_input),
		.analog_in(analog_in),
		.pid_freq(pid_freq),
		.freq_ref(freq_ref),
		.stop_req(stop_req),
		.loss_active(loss_active)
	);

	dfc_cmd_model i_dfc_cmd_model
	(
		.clk(clk),
		.analog_in(analog_in),
		.pid_freq(pid_freq),
		.general_input(general_input)
	);

	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task ckr(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK("reg_rdata", e, d)
	endtask : ckr

	// Waits past the three edges digital inputs need through the synchroniser
	task ck(input dfc_pkg::dfc_freq_type e);
		repeat (4) @(posedge clk);
		#1;
		`CHK("freq_ref", e, freq_ref)
	endtask : ck

	task results;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	initial
	begin
		#(dfc_pkg::CLK_PERIOD_NS * 20000);
		err_total++;
		results();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 16; i++)
			ckr(ra[i], rv[i]);
		wr(8'h40, 32'h1234);
		ckr(8'h40, 32'h0);
		// Link path is the reset default
		wr(dfc_pkg::A_LINK_H, 32'h04d2);
		ck(18'sd1234);
		wr(dfc_pkg::A_LINK_S, 32'h2710);
		ck(18'sd3000);
		wr(dfc_pkg::A_LINK_S, 32'hb1e0);
		ck(-18'sd6000);
		wr(dfc_pkg::A_LINK_S, 32'h8000);
		ck(-18'sd6000);
		wr(dfc_pkg::A_LINK_S, 32'h0);
		ck(18'sd1234);
		// Keypad with limits
		wr(dfc_pkg::A_CTRL, 32'h0);
		wr(dfc_pkg::A_KEYPAD, 32'h09c4);
		ck(18'sd2500);
		wr(dfc_pkg::A_HIGH, 32'h07d0);
		ck(18'sd2000);
		wr(dfc_pkg::A_HIGH, 32'h1770);
		wr(dfc_pkg::A_LOW, 32'h03e8);
		wr(dfc_pkg::A_KEYPAD, 32'h01f4);
		ck(18'sd1000);
		wr(dfc_pkg::A_CTRL, 32'h4);
		ck(18'sd0);
		`CHK("stop_req", 1'b1, stop_req)
		wr(dfc_pkg::A_LOW, 32'h0);
		wr(dfc_pkg::A_KEYPAD, 32'h09c4);
		wr(dfc_pkg::A_CTRL, 32'h2);
		ck(18'sd2500);
		// Terminal 12 gain, bias, polarity and inverse
		wr(dfc_pkg::A_CTRL, 32'h0);
		wr(dfc_pkg::A_PRI_SRC, 32'h1);
		i_dfc_cmd_model.set_term(18'sd1500);
		ck(18'sd1500);
		wr(dfc_pkg::A_GAIN_PRI, 32'h2000);
		ck(18'sd3000);
		wr(dfc_pkg::A_GAIN_PRI, 32'h1000);
		wr(dfc_pkg::A_BIAS_PRI, 32'h00c8);
		ck(18'sd1700);
		wr(dfc_pkg::A_BIAS_PRI, 32'hf830);
		ck(-18'sd500);
		wr(dfc_pkg::A_CTRL, 32'h1);
		ck(18'sd0);
		wr(dfc_pkg::A_BIAS_PRI, 32'h0);
		wr(dfc_pkg::A_CTRL, 32'h2);
		ck(18'sd4500);
		// Secondary source takes gain only
		wr(dfc_pkg::A_SEC_SRC, 32'h1);
		wr(dfc_pkg::A_GAIN_SEC, 32'h2000);
		wr(dfc_pkg::A_BIAS_PRI, 32'h00c8);
		wr(dfc_pkg::A_CTRL, 32'h8);
		i_dfc_cmd_model.set_term(18'sd1000);
		ck(18'sd2000);
		wr(dfc_pkg::A_CTRL, 32'h0);
		wr(dfc_pkg::A_BIAS_PRI, 32'h0);
		// Multi-purpose terminal absent then present
		wr(dfc_pkg::A_PRI_SRC, 32'h2);
		i_dfc_cmd_model.set_cur(1'b0, 18'sd800);
		ck(18'sd0);
		i_dfc_cmd_model.set_cur(1'b1, 18'sd800);
		ck(18'sd800);
		wr(dfc_pkg::A_CTRL, 32'h40);
		ck(18'sd0);
		wr(dfc_pkg::A_PRI_SRC, 32'h3);
		ck(18'sd800);
		wr(dfc_pkg::A_CTRL, 32'h60);
		ck(18'sd0);
		wr(dfc_pkg::A_CTRL, 32'h0);
		// Command loss on terminal 12
		wr(dfc_pkg::A_PRI_SRC, 32'h1);
		i_dfc_cmd_model.set_term(18'sd2000);
		wr(dfc_pkg::A_LOSS, 32'h32);
		ck(18'sd2000);
		i_dfc_cmd_model.set_loss(3'h6);
		ck(18'sd2000);
		`CHK("loss_active", 1'b0, loss_active)
		i_dfc_cmd_model.set_loss(3'h1);
		ck(18'sd1000);
		`CHK("loss_active", 1'b1, loss_active)
		// Loss action is taken at the onset of a loss, so the loss is dropped first
		i_dfc_cmd_model.set_loss(3'h0);
		wr(dfc_pkg::A_LOSS, 32'h0);
		i_dfc_cmd_model.set_loss(3'h1);
		ck(18'sd0);
		wr(dfc_pkg::A_LOSS, 32'hff);
		ck(18'sd2000);
		`CHK("loss_active", 1'b0, loss_active)
		i_dfc_cmd_model.set_loss(3'h0);
		// Process loop modes override the selection
		i_dfc_cmd_model.set_pid(18'sd2222);
		for (int m = 1; m < 4; m++)
		begin
			wr(dfc_pkg::A_CTRL, 32'(m) << 12);
			ck(18'sd2222);
		end
		wr(dfc_pkg::A_CTRL, 32'h0);
		ck(18'sd2000);
		// Terminal 12 as aux one, current input as aux two
		wr(dfc_pkg::A_AUX_CFG, 32'h9);
		ck(18'sd4800);
		wr(dfc_pkg::A_AUX_CFG, 32'h0);
		// Link enable mapped to the third input
		wr(dfc_pkg::A_PRI_SRC, 32'h0);
		wr(dfc_pkg::A_KEYPAD, 32'h02bc);
		wr(dfc_pkg::A_CTRL, 32'h0300);
		ck(18'sd700);
		i_dfc_cmd_model.set_inputs(5'h04);
		ck(18'sd1234);
		i_dfc_cmd_model.set_inputs(5'h1f);
		ck(18'sd1234);
		ckr(dfc_pkg::A_STATUS, 32'h067c_04d2);
		results();
	end
endmodule : dfc_core_tb
